// *** src/sw_cmd_regs.svh ***
// constants of the single-wire bit and byte command handlers
`ifndef SW_CMD_REGS_SVH
`define SW_CMD_REGS_SVH

// command codes
`define SW_CODE_SINGLE_BIT   8'h87
`define SW_CODE_WRITE_BYTE   8'hA5

// field position of the slot type in the single-bit parameter byte
`define SW_SLOT_TYPE_BIT     7

// slots per command
`define SW_SLOTS_BIT         4'h1
`define SW_SLOTS_BYTE        4'h8

// clock period and the latest start of line activity
`define SW_CLK_PERIOD_NS     40
`define SW_ACT_MAX_NS        1090
`define SW_ACT_MAX_CYC       ((`SW_ACT_MAX_NS) / (`SW_CLK_PERIOD_NS))

// reset values of the status outputs
`define SW_BUSY_RST          1'b0
`define SW_RESULT_RST        1'b0
`define SW_PTR_RST           1'b0

`endif

// *** src/sw_cmd_pkg.sv ***
// types shared by the single-wire command handlers
package sw_cmd_pkg;

    // command sequencer states
    typedef enum logic [1:0] {
        CMD_IDLE,
        CMD_WAIT_PARAM,
        CMD_RUN
    } cmd_state_t;

    // time slot phases
    typedef enum logic [1:0] {
        SLOT_IDLE,
        SLOT_LOW,
        SLOT_HIGH,
        SLOT_REC
    } slot_phase_t;

    // which command waits for its parameter
    typedef enum logic {
        KIND_BIT,
        KIND_BYTE
    } cmd_kind_t;

endpackage

// *** src/sw_slot_gen.sv ***
// one time slot on the single-wire line: low phase, release, sample, recovery
`timescale 1ns/1ps
module sw_slot_gen
(
    // clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    // slot request and timing, all in clock cycles
    input  wire logic        i_start,
    input  wire logic [11:0] i_low_cyc,
    input  wire logic [11:0] i_slot_cyc,
    input  wire logic [11:0] i_sample_cyc,
    input  wire logic [11:0] i_rec_cyc,
    // synchronised line level
    input  wire logic        i_line,
    // slot outputs
    output logic             o_line_oe,
    output logic             o_sample_stb,
    output logic             o_sample,
    output logic             o_rec,
    output logic             o_done
);

    // ----------------------------------------------------------------
    // slot state
    // ----------------------------------------------------------------
    sw_cmd_pkg::slot_phase_t phase_q, phase_d;   // slot phase
    logic [11:0]             cnt_q, cnt_d;       // cycles since slot start, restarted from zero for recovery
    logic                    oe_q, oe_d;         // pulling the line low
    logic                    stb_q, stb_d;       // sample taken this cycle
    logic                    smp_q, smp_d;       // sampled level
    logic                    done_q, done_d;     // slot finished pulse

    // next slot state
    always_comb
    begin
        phase_d = phase_q;
        cnt_d   = cnt_q;
        oe_d    = oe_q;
        stb_d   = 1'b0;
        smp_d   = smp_q;
        done_d  = 1'b0;
        // sample the line at the sample point, in the low or high phase only
        if ((phase_q == sw_cmd_pkg::SLOT_LOW || phase_q == sw_cmd_pkg::SLOT_HIGH)
            && cnt_q == i_sample_cyc)
        begin
            stb_d = 1'b1;
            smp_d = i_line;
        end
        case (phase_q)
            sw_cmd_pkg::SLOT_IDLE:
            begin
                // start pulls the line low at once
                if (i_start)
                begin
                    phase_d = sw_cmd_pkg::SLOT_LOW;
                    cnt_d   = 12'h000;
                    oe_d    = 1'b1;
                end
            end
            sw_cmd_pkg::SLOT_LOW:
            begin
                cnt_d = cnt_q + 12'h001;
                // release after the low time, at least one cycle
                if (cnt_q + 12'h001 >= i_low_cyc)
                begin
                    phase_d = sw_cmd_pkg::SLOT_HIGH;
                    oe_d    = 1'b0;
                end
            end
            sw_cmd_pkg::SLOT_HIGH:
            begin
                cnt_d = cnt_q + 12'h001;
                // end of the slot proper, then recovery
                if (cnt_q + 12'h001 >= i_slot_cyc)
                begin
                    phase_d = sw_cmd_pkg::SLOT_REC;
                    cnt_d   = 12'h000;
                end
            end
            sw_cmd_pkg::SLOT_REC:
            begin
                cnt_d = cnt_q + 12'h001;
                // recovery over: slot done
                if (cnt_q + 12'h001 >= i_rec_cyc)
                begin
                    phase_d = sw_cmd_pkg::SLOT_IDLE;
                    done_d  = 1'b1;
                end
            end
            default:
            begin
                phase_d = sw_cmd_pkg::SLOT_IDLE;
                oe_d    = 1'b0;
            end
        endcase
    end

    // register slot state
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            phase_q <= sw_cmd_pkg::SLOT_IDLE;
            cnt_q   <= 12'h000;
            oe_q    <= 1'b0;
            stb_q   <= 1'b0;
            smp_q   <= 1'b0;
            done_q  <= 1'b0;
        end
        else if (i_clk_en)
        begin
            phase_q <= phase_d;
            cnt_q   <= cnt_d;
            oe_q    <= oe_d;
            stb_q   <= stb_d;
            smp_q   <= smp_d;
            done_q  <= done_d;
        end
    end

    assign o_line_oe    = oe_q;
    assign o_sample_stb = stb_q;
    assign o_sample     = smp_q;
    assign o_done       = done_q;
    assign o_rec        = (phase_q == sw_cmd_pkg::SLOT_REC);

endmodule

// *** src/sw_bit_byte_cmd.sv ***
// single-bit and write-byte command handlers of a single-wire line master
`timescale 1ns/1ps
`include "sw_cmd_regs.svh"

// Functional notes
// - single-bit code 87h, one parameter byte
// - parameter bit 7 selects zero or one slot
// - sample line at sample point into result
// - busy line: code not acknowledged, ignored
// - line activity starts within 1.09us
// - single-bit busy one slot time
// - write-byte code A5h, one data byte
// - write-byte gives eight slots, eight slot times
// - data sent least significant bit first
// - wait for whole byte before slots
// - read pointer left on master status
// - slots use current speed and pullup settings
// - write-one slot reads the line bit
module sw_bit_byte_cmd
#(
    parameter int SLOT_STD_CYC   = 1500,  // standard slot length in cycles
    parameter int SLOT_OD_CYC    = 250,   // overdrive slot length in cycles
    parameter int SAMPLE_STD_CYC = 375,   // standard sample point in cycles
    parameter int SAMPLE_OD_CYC  = 50     // overdrive sample point in cycles
)
(
    // clock, reset, enable
    input  wire logic        i_sys_clk,
    input  wire logic        i_reset,
    input  wire logic        i_clk_en,
    // received command stream from the host interface
    input  wire logic        i_byte_valid,
    input  wire logic        i_byte_is_code,
    input  wire logic [7:0]  i_byte_data,
    input  wire logic        i_read_ptr_moved,
    // configuration
    input  wire logic        i_overdrive_speed_select,
    input  wire logic        i_active_pullup_select,
    input  wire logic        i_strong_pullup_select,
    input  wire logic [11:0] i_write_zero_low_time,
    input  wire logic [11:0] i_write_one_low_time,
    input  wire logic [11:0] i_recovery_time,
    input  wire logic        i_weak_pullup_value,
    // line pin (open drain)
    input  wire logic        i_line_in,
    output logic             o_line_out,
    output logic             o_line_oe,
    output logic             o_active_pullup_en,
    output logic             o_strong_pullup_en,
    output logic             o_weak_pullup_value,
    // handshake and status
    output logic             o_code_ack,
    output logic             o_line_busy_flag,
    output logic             o_single_bit_result_flag,
    output logic             o_read_ptr_at_status
);

    // ----------------------------------------------------------------
    // line input synchroniser
    // ----------------------------------------------------------------
    logic sync1_q, sync1_d;   // first stage, read only by the second
    logic sync2_q, sync2_d;   // synchronised line level

    // next synchroniser values
    always_comb
    begin
        sync1_d = i_line_in;
        sync2_d = sync1_q;
    end

    // register synchroniser
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            sync1_q <= 1'b1;
            sync2_q <= 1'b1;
        end
        else if (i_clk_en)
        begin
            sync1_q <= sync1_d;
            sync2_q <= sync2_d;
        end
    end

    // ----------------------------------------------------------------
    // slot timing selection
    // ----------------------------------------------------------------
    logic [11:0] slot_cyc;     // slot length for current speed
    logic [11:0] sample_cyc;   // sample point for current speed
    logic [11:0] low_cyc;      // low time of the next slot
    logic        slot_start;   // launch one slot
    logic        slot_oe;      // slot engine pulls low
    logic        slot_stb;     // sample strobe
    logic        slot_smp;     // sampled level
    logic        slot_rec;     // slot in recovery
    logic        slot_done;    // slot finished
    logic [7:0]  shift_q, shift_d;   // bits still to send, bit 0 next

    // timing from the settings as they stand now
    always_comb
    begin
        slot_cyc   = i_overdrive_speed_select ? SLOT_OD_CYC[11:0] : SLOT_STD_CYC[11:0];
        sample_cyc = i_overdrive_speed_select ? SAMPLE_OD_CYC[11:0]
                                              : SAMPLE_STD_CYC[11:0];
        // write-one slot doubles as the read slot
        low_cyc    = shift_q[0] ? i_write_one_low_time : i_write_zero_low_time;
    end

    sw_slot_gen u_slot
    (
        .i_sys_clk    (i_sys_clk),
        .i_reset      (i_reset),
        .i_clk_en     (i_clk_en),
        .i_start      (slot_start),
        .i_low_cyc    (low_cyc),
        .i_slot_cyc   (slot_cyc),
        .i_sample_cyc (sample_cyc),
        .i_rec_cyc    (i_recovery_time),
        .i_line       (sync2_q),
        .o_line_oe    (slot_oe),
        .o_sample_stb (slot_stb),
        .o_sample     (slot_smp),
        .o_rec        (slot_rec),
        .o_done       (slot_done)
    );

    // ----------------------------------------------------------------
    // command sequencer
    // ----------------------------------------------------------------
    sw_cmd_pkg::cmd_state_t state_q, state_d;   // sequencer state
    sw_cmd_pkg::cmd_kind_t  kind_q, kind_d;     // command being run
    logic [3:0]             left_q, left_d;     // slots still to run
    logic                   start_q, start_d;   // slot launch request
    logic                   ack_q, ack_d;       // code acknowledge
    logic                   busy_q, busy_d;     // line busy flag
    logic                   sbr_q, sbr_d;       // single-bit result
    logic                   ptr_q, ptr_d;       // read pointer on status
    logic                   spu_q, spu_d;       // strong pullup after command

    assign slot_start = start_q;

    // next sequencer values
    always_comb
    begin
        state_d = state_q;
        kind_d  = kind_q;
        shift_d = shift_q;
        left_d  = left_q;
        start_d = 1'b0;
        ack_d   = 1'b0;
        busy_d  = busy_q;
        sbr_d   = sbr_q;
        ptr_d   = ptr_q;
        spu_d   = spu_q;
        // any later pointer move by the host interface wins over the hold
        if (i_read_ptr_moved)
        begin
            ptr_d = 1'b0;
        end
        case (state_q)
            sw_cmd_pkg::CMD_IDLE:
            begin
                // a code arriving while busy is neither acknowledged nor kept
                if (i_byte_valid && i_byte_is_code && !busy_q)
                begin
                    if (i_byte_data == `SW_CODE_SINGLE_BIT)
                    begin
                        ack_d   = 1'b1;
                        kind_d  = sw_cmd_pkg::KIND_BIT;
                        state_d = sw_cmd_pkg::CMD_WAIT_PARAM;
                    end
                    else if (i_byte_data == `SW_CODE_WRITE_BYTE)
                    begin
                        ack_d   = 1'b1;
                        kind_d  = sw_cmd_pkg::KIND_BYTE;
                        state_d = sw_cmd_pkg::CMD_WAIT_PARAM;
                    end
                end
            end
            sw_cmd_pkg::CMD_WAIT_PARAM:
            begin
                // a new code abandons the pending command
                if (i_byte_valid && i_byte_is_code)
                begin
                    state_d = sw_cmd_pkg::CMD_IDLE;
                end
                // whole parameter byte in hand: start within one cycle
                else if (i_byte_valid)
                begin
                    busy_d  = 1'b1;
                    start_d = 1'b1;
                    spu_d   = 1'b0;
                    ptr_d   = 1'b1;
                    state_d = sw_cmd_pkg::CMD_RUN;
                    if (kind_q == sw_cmd_pkg::KIND_BIT)
                    begin
                        // only the slot type bit matters
                        shift_d = {7'h00, i_byte_data[`SW_SLOT_TYPE_BIT]};
                        left_d  = `SW_SLOTS_BIT;
                    end
                    else
                    begin
                        shift_d = i_byte_data;
                        left_d  = `SW_SLOTS_BYTE;
                    end
                end
            end
            sw_cmd_pkg::CMD_RUN:
            begin
                // sampled level of a single-bit slot becomes the result
                if (slot_stb && kind_q == sw_cmd_pkg::KIND_BIT)
                begin
                    sbr_d = slot_smp;
                end
                if (slot_done)
                begin
                    shift_d = {1'b0, shift_q[7:1]};
                    left_d  = left_q - 4'h1;
                    if (left_q == 4'h1)
                    begin
                        busy_d  = 1'b0;
                        spu_d   = i_strong_pullup_select;
                        state_d = sw_cmd_pkg::CMD_IDLE;
                    end
                    else
                    begin
                        start_d = 1'b1;
                    end
                end
            end
            default:
            begin
                state_d = sw_cmd_pkg::CMD_IDLE;
                busy_d  = 1'b0;
            end
        endcase
    end

    // register sequencer state
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            state_q <= sw_cmd_pkg::CMD_IDLE;
            kind_q  <= sw_cmd_pkg::KIND_BIT;
            shift_q <= 8'h00;
            left_q  <= 4'h0;
            start_q <= 1'b0;
            ack_q   <= 1'b0;
            busy_q  <= `SW_BUSY_RST;
            sbr_q   <= `SW_RESULT_RST;
            ptr_q   <= `SW_PTR_RST;
            spu_q   <= 1'b0;
        end
        else if (i_clk_en)
        begin
            state_q <= state_d;
            kind_q  <= kind_d;
            shift_q <= shift_d;
            left_q  <= left_d;
            start_q <= start_d;
            ack_q   <= ack_d;
            busy_q  <= busy_d;
            sbr_q   <= sbr_d;
            ptr_q   <= ptr_d;
            spu_q   <= spu_d;
        end
    end

    // ----------------------------------------------------------------
    // pin drivers
    // ----------------------------------------------------------------
    logic oe_q, oe_d;       // line pulled low
    logic apu_q, apu_d;     // active pullup during recovery
    logic wpu_q, wpu_d;     // weak pullup selection

    // next pin values
    always_comb
    begin
        oe_d  = slot_oe;
        apu_d = slot_rec && i_active_pullup_select;
        wpu_d = i_weak_pullup_value;
    end

    // register pin drivers
    always_ff @(posedge i_sys_clk)
    begin
        if (i_reset)
        begin
            oe_q  <= 1'b0;
            apu_q <= 1'b0;
            wpu_q <= 1'b0;
        end
        else if (i_clk_en)
        begin
            oe_q  <= oe_d;
            apu_q <= apu_d;
            wpu_q <= wpu_d;
        end
    end

    // outputs straight from flip-flops, o_line_out tied low; the line is only ever pulled low
    assign o_line_out               = 1'b0;
    assign o_line_oe                = oe_q;
    assign o_active_pullup_en       = apu_q;
    assign o_strong_pullup_en       = spu_q;
    assign o_weak_pullup_value      = wpu_q;
    assign o_code_ack               = ack_q;
    assign o_line_busy_flag         = busy_q;
    assign o_single_bit_result_flag = sbr_q;
    assign o_read_ptr_at_status     = ptr_q;

endmodule

// *** verification/sw_cmd_sva.sv ***
// checker of the single-wire bit and byte command handlers
`timescale 1ns/1ps
module sw_cmd_sva
#(
    parameter int SLOT_OD_CYC = 250  // shortest slot length in cycles
)
(
    // clock, stream and pullup settings
    input wire logic       i_sys_clk,
    input wire logic       i_reset,
    input wire logic       i_clk_en,
    input wire logic       i_byte_valid,
    input wire logic       i_byte_is_code,
    input wire logic [7:0] i_byte_data,
    input wire logic       i_active_pullup_select,
    input wire logic       i_weak_pullup_value,
    // outputs watched
    input wire logic       o_line_oe,
    input wire logic       o_active_pullup_en,
    input wire logic       o_strong_pullup_en,
    input wire logic       o_weak_pullup_value,
    input wire logic       o_code_ack,
    input wire logic       o_line_busy_flag,
    input wire logic       o_single_bit_result_flag,
    input wire logic       o_read_ptr_at_status
);
    localparam int ACT_CYC = 27;  // latest start of line activity
    logic        pend_q;  // code taken, parameter awaited
    logic        pend_d;
    logic        acc;     // code accepted at this edge
    logic        prm;     // parameter accepted at this edge
    logic [15:0] run_q;   // busy cycles so far
    logic [15:0] run_d;
    // ----------------------------------------
    // helper state
    // ----------------------------------------
    always_comb
    begin
        acc = i_clk_en & i_byte_valid & i_byte_is_code & !o_line_busy_flag & !pend_q
            & ((i_byte_data == 8'h87) | (i_byte_data == 8'hA5));
        prm = pend_q & i_clk_en & i_byte_valid & !i_byte_is_code;
        pend_d = acc ? 1'b1 : ((i_clk_en & i_byte_valid) ? 1'b0 : pend_q);
        run_d = o_line_busy_flag ? run_q + 16'h0001 : 16'h0000;
    end
    always_ff @(posedge i_sys_clk)
    begin
        pend_q <= i_reset ? 1'b0 : pend_d;
        run_q <= i_reset ? 16'h0000 : run_d;
    end
    // ----------------------------------------
    // properties
    // ----------------------------------------
    default clocking cb @(posedge i_sys_clk);
    endclocking
    default disable iff (i_reset);
    property p_ack;
        acc |=> o_code_ack;
    endproperty
    a_ack: assert property (p_ack) else $error("code not acknowledged");
    property p_ack_only;
        o_code_ack |-> $past(acc);
    endproperty
    a_ack_only: assert property (p_ack_only) else $error("stray acknowledge");
    property p_param;
        prm |=> o_line_busy_flag & o_read_ptr_at_status;
    endproperty
    a_param: assert property (p_param) else $error("busy or pointer not set");
    property p_act;
        prm |-> ##[1:ACT_CYC] o_line_oe;
    endproperty
    a_act: assert property (p_act) else $error("line activity late");
    property p_idle;
        !o_line_busy_flag |-> !o_line_oe;
    endproperty
    a_idle: assert property (p_idle) else $error("line driven while idle");
    property p_hold;
        !o_line_busy_flag |=> $stable(o_single_bit_result_flag);
    endproperty
    a_hold: assert property (p_hold) else $error("result moved while idle");
    property p_min;
        $fell(o_line_busy_flag) && !$past(i_reset) |-> run_q >= SLOT_OD_CYC;
    endproperty
    a_min: assert property (p_min) else $error("busy shorter than a slot");
    property p_weak;
        i_clk_en |=> o_weak_pullup_value == $past(i_weak_pullup_value);
    endproperty
    a_weak: assert property (p_weak) else $error("weak pullup not copied");
    property p_apu;
        o_active_pullup_en |-> $past(i_active_pullup_select) && o_line_busy_flag;
    endproperty
    a_apu: assert property (p_apu) else $error("active pullup unselected");
    c_acc: cover property (acc);
    c_refuse: cover property (i_byte_valid & i_byte_is_code & o_line_busy_flag);
    c_spu: cover property (o_strong_pullup_en);
    c_end: cover property ($fell(o_line_busy_flag));
endmodule

bind sw_bit_byte_cmd sw_cmd_sva #(.SLOT_OD_CYC(SLOT_OD_CYC)) u_sva
(
    .i_sys_clk(i_sys_clk),
    .i_reset(i_reset),
    .i_clk_en(i_clk_en),
    .i_byte_valid(i_byte_valid),
    .i_byte_is_code(i_byte_is_code),
    .i_byte_data(i_byte_data),
    .i_active_pullup_select(i_active_pullup_select),
    .i_weak_pullup_value(i_weak_pullup_value),
    .o_line_oe(o_line_oe),
    .o_active_pullup_en(o_active_pullup_en),
    .o_strong_pullup_en(o_strong_pullup_en),
    .o_weak_pullup_value(o_weak_pullup_value),
    .o_code_ack(o_code_ack),
    .o_line_busy_flag(o_line_busy_flag),
    .o_single_bit_result_flag(o_single_bit_result_flag),
    .o_read_ptr_at_status(o_read_ptr_at_status)
);

// *** verification/sw_line_slave.sv ***
// behavioural slave on the single-wire line
`timescale 1ns/1ps
module sw_line_slave
#(
    parameter int SAMPLE_AT = 7,  // cycles from slot start to slave sample
    parameter int HOLD_CYC  = 14  // cycles the slave holds a zero answer
)
(
    input  wire logic       i_clk,
    input  wire logic       i_line,    // resolved line level
    input  wire logic       i_answer,  // bit returned in read slots
    input  wire logic       i_clear,   // forget captured bits
    output logic            o_pull,    // slave pulls the line low
    output logic [7:0]      o_byte,    // first slot ends in bit 0
    output logic [3:0]      o_count    // slots seen
);
    int   age = 100;    // cycles since slot start
    logic last = 1'b1;  // line one cycle back
    initial o_pull = 1'b0;
    initial o_byte = 8'h00;
    initial o_count = 4'h0;
    // slot detection, capture and answer
    always @(posedge i_clk)
    begin
        last <= i_line;
        age <= (last && !i_line) ? 1 : age + 1;
        if (last && !i_line)
            o_pull <= !i_answer;  // zero answer in a read slot
        else if (age >= HOLD_CYC)
            o_pull <= 1'b0;       // released line goes to the pullup level
        if (i_clear)
        begin
            o_byte <= 8'h00;
            o_count <= 4'h0;
        end
        else if (age == SAMPLE_AT)
        begin
            o_byte <= {i_line, o_byte[7:1]};  // shifts toward bit 0
            o_count <= o_count + 4'h1;
        end
    end
endmodule

// *** verification/test_single_wire_bit_byte_commands.sv ***
// self-checking bench of the single-wire bit and byte commands
`timescale 1ns/1ps
module test_single_wire_bit_byte_commands;
    localparam int SLOT_STD = 40;  // shortened slot lengths
    localparam int SLOT_OD  = 20;
    logic        clk = 1'b0;
    logic        rst = 1'b1;
    logic        vld = 1'b0;
    logic        is_code = 1'b0;
    logic [7:0]  bdata = 8'h00;
    logic        ptr_mv = 1'b0;
    logic        od = 1'b0;
    logic        active_pullup_select = 1'b0;
    logic        strong_pullup_select = 1'b0;
    logic [11:0] rec = 12'h002;
    logic        wpu = 1'b0;
    logic [11:0] w0l = 12'h00C;  // write-zero low, past the slave sample point
    logic [11:0] w1l = 12'h002;  // write-one low, over before the master samples
    logic        answer = 1'b1;
    logic        clr = 1'b0;
    logic        lout, oe, ap_en, sp_en, wpu_o, ack, busy, result, ptr, pull;
    logic [7:0]  sbyte;
    logic [3:0]  scount;
    logic [31:0] seed = 32'h00009C8F;
    logic [7:0]  corner [4] = '{8'h7F, 8'h01, 8'h80, 8'hFE};
    int          err_total = 0;
    int          checks_done = 0;
    wire         line = ~(oe | pull);  // open drain with pullup
    always #20 clk = ~clk;
    sw_bit_byte_cmd #(.SLOT_STD_CYC(40), .SLOT_OD_CYC(20), .SAMPLE_STD_CYC(10),
        .SAMPLE_OD_CYC(5)) u_dut
    (
        .i_sys_clk(clk), .i_reset(rst), .i_clk_en(1'b1), .i_byte_valid(vld),
        .i_byte_is_code(is_code), .i_byte_data(bdata), .i_read_ptr_moved(ptr_mv),
        .i_overdrive_speed_select(od), .i_active_pullup_select(active_pullup_select),
        .i_strong_pullup_select(strong_pullup_select), .i_write_zero_low_time(w0l),
        .i_write_one_low_time(w1l), .i_recovery_time(rec),
        .i_weak_pullup_value(wpu), .i_line_in(line), .o_line_out(lout), .o_line_oe(oe),
        .o_active_pullup_en(ap_en), .o_strong_pullup_en(sp_en),
        .o_weak_pullup_value(wpu_o), .o_code_ack(ack), .o_line_busy_flag(busy),
        .o_single_bit_result_flag(result), .o_read_ptr_at_status(ptr)
    );
    sw_line_slave u_slave
    (
        .i_clk(clk), .i_line(line), .i_answer(answer), .i_clear(clr),
        .o_pull(pull), .o_byte(sbyte), .o_count(scount)
    );
    // xorshift source
    function logic [31:0] rnd();
        seed ^= seed << 13;
        seed ^= seed >> 17;
        seed ^= seed << 5;
        return seed;
    endfunction
    task end_sim;
        if (err_total == 0 && checks_done > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask
    task check(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        checks_done++;
        if (seen !== exp)
        begin
            err_total++;
            $display("mismatch %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task tick;
        @(posedge clk);
        #2;
    endtask
    // one byte from the host side; a holds the ack seen after the taking edge
    task send(input logic c, input logic [7:0] d, output logic a);
        vld = 1'b1;
        is_code = c;
        bdata = d;
        tick;
        a = ack;
        vld = 1'b0;
        tick;
    endtask
    task wait_idle(output int n);
        n = 0;
        while (busy !== 1'b0 && n < 5000)
        begin
            tick;
            n++;
        end
        if (n >= 5000)
        begin
            err_total++;
            end_sim;
        end
    endtask
    // full command with busy length bounds
    task cmd(input logic [7:0] code, input logic [7:0] prm, input int slots);
        logic a;
        int   n;
        int   lo;
        lo = slots * ((od ? SLOT_OD : SLOT_STD) + int'(rec));
        send(1'b1, code, a);
        check("ack", a, 1);
        send(1'b0, prm, a);
        check("busy", busy, 1);
        wait_idle(n);
        check("busy_lo", n + 2 >= lo, 1);
        check("busy_hi", n + 2 <= lo + 27, 1);
        check("ptr", ptr, 1);
    endtask
    initial
    begin
        logic [31:0] r;
        logic [7:0]  p;
        logic        a;
        int          n;
        repeat (5) tick;
        rst = 1'b0;
        check("idle", {lout, oe, busy, ack, result, ptr}, 0);
        for (int k = 0; k < 20; k++)
        begin
            r = rnd();
            {wpu, strong_pullup_select, active_pullup_select, od} = r[3:0];
            rec = {9'h000, r[6:4]} + 12'h001;
            w0l = {9'h000, r[18:16]} + 12'h008;
            w1l = {11'h000, r[19]} + 12'h001;
            answer = (k < 4) | r[7];
            p = (k < 4) ? corner[k] : r[15:8];
            if (k % 2 == 0)
            begin
                cmd(8'h87, p, 1);
                check("result", result, p[7] & answer);
            end
            else
            begin
                answer = 1'b1;
                clr = 1'b1;
                tick;
                clr = 1'b0;
                cmd(8'hA5, p, 8);
                check("byte", sbyte, p);
                check("slots", scount, 8);
            end
            check("spu", sp_en, strong_pullup_select);
            check("wpu", wpu_o, wpu);
        end
        // codes while the line is busy are refused
        send(1'b1, 8'h87, a);
        send(1'b0, 8'h00, a);
        send(1'b1, 8'h87, a);
        check("busy_87", a, 0);
        send(1'b1, 8'hA5, a);
        check("busy_A5", a, 0);
        wait_idle(n);
        // unknown code, stray parameter and cancelled wait
        send(1'b1, 8'h96, a);
        check("bad", a, 0);
        send(1'b1, 8'hA5, a);
        send(1'b1, 8'h87, a);
        check("cancel", a, 0);
        send(1'b0, 8'h80, a);
        check("stray", busy, 0);
        ptr_mv = 1'b1;
        tick;
        ptr_mv = 1'b0;
        tick;
        check("ptr_off", ptr, 0);
        end_sim;
    end
endmodule
